// *** rtl/oamsc_regs.sv ***
// Maintenance frame counters, partner status shadow and local status byte.
// Assumes an APB master on pclk and frame events that are one-cycle pulses.
// How it works
// - Transmit counter steps once for every valid maintenance frame sent.
// - Receive counter steps only for good CRC, valid opcode, valid direction.
// - Both counters are 8 bits, count up to 255, reset to zero.
// - Writing zero to control register 0x44 clears both counters.
// - Terminal side: shadow mirrors partner status whenever optical link is up.
// - Center side: shadow copies partner status when link up after power-on.
// - Center side: warm reset or power-down keep the shadow value.
// - Center side: after link returns, shadow mirrors again while link up.
// - Status bit 6 is 1 on terminal side, 0 on center side.
// - Status bit 5 is 1 while in any loopback state.
// - Status bit 4 picks loss reporting; terminal side loads it from a pin.
// - Status bit 3 is diagnostic fail; terminal side follows the diag pin.
// - Status bit 2 is copper link down, resets to 1, hardware on terminal.
// - Status bit 1 is 1 when no optical signal is detected.
// - Optical signal absence comes from polling the fiber detect pin.
// - Partner status byte uses the same layout as the local status byte.
`timescale 1ns/1ps
module oamsc_regs #(
   parameter int CNT_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic por_n,
   input wire logic [31:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic terminal_mode,
   input wire logic opt_link_up,
   input wire logic [7:0] partner_status,
   input wire logic tx_frame_valid,
   input wire logic rx_frame_done,
   input wire logic rx_crc_good,
   input wire logic rx_opcode_valid,
   input wire logic rx_dir_valid,
   input wire oamsc_pkg::oamsc_loop_t loop_states,
   input wire logic link_speed,
   input wire logic loss_method_pin,
   input wire logic diag_fail_pin,
   input wire logic copper_link_down,
   input wire logic fiber_signal_detect_pin,
   input wire logic powerdown_pin_n,
   output oamsc_pkg::oamsc_status_t local_status,
   output logic irq
);
   // Read path and wrap events are built for byte-wide counters only
   if (CNT_W != 8) begin : g_cnt_w_check
      $error("counter width must be 8");
   end

   logic [CNT_W-1:0] maint_tx_frame_count;
   logic [CNT_W-1:0] maint_rx_frame_count;
   logic [7:0] partner_status_shadow;
   logic [7:0] ctrl_reg;
   logic cpu_loss_method;
   logic cpu_diag;
   logic cpu_copper_down;
   logic [oamsc_pkg::IRQ_W-1:0] irq_stat;
   logic [oamsc_pkg::IRQ_W-1:0] irq_mask;
   logic opt_abs_q;
   logic opt_primed;
   logic seen_por_release;
   logic [31:0] next_prdata;
   oamsc_pkg::oamsc_status_t status_now;

   function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
      hit = (a[31:2] == {22'h0, idx}) && (a[1:0] == 2'b00);
   endfunction

   wire wr_en = psel && penable && pwrite;
   wire rd_en = psel && !penable && !pwrite;
   wire lane0 = pstrb[0];
   wire hit_ctrl = hit(paddr, oamsc_pkg::IDX_CTRL);
   wire hit_tx = hit(paddr, oamsc_pkg::IDX_TX_CNT);
   wire hit_rx = hit(paddr, oamsc_pkg::IDX_RX_CNT);
   wire hit_sh = hit(paddr, oamsc_pkg::IDX_SHADOW);
   wire hit_st = hit(paddr, oamsc_pkg::IDX_STATUS);
   wire hit_is = hit(paddr, oamsc_pkg::IDX_IRQ_STAT);
   wire hit_im = hit(paddr, oamsc_pkg::IDX_IRQ_MASK);
   wire mapped = hit_ctrl | hit_tx | hit_rx | hit_sh | hit_st | hit_is | hit_im;
   wire clr_cnt = wr_en && hit_ctrl && lane0 && pwdata[7:0] == oamsc_pkg::CTRL_CLEAR_VAL;
   wire rx_good = rx_frame_done && rx_crc_good && rx_opcode_valid && rx_dir_valid;
   wire st_wr = wr_en && hit_st && lane0 && !terminal_mode;
   // Shadow tracks partner only while optical link is up; otherwise holds
   wire shadow_load = opt_link_up && seen_por_release;
   // Center side freezes the copy while powered down
   wire shadow_take = shadow_load && (terminal_mode || powerdown_pin_n);
   // First cycle after reset skipped so the reset value raises no event
   wire [oamsc_pkg::IRQ_W-1:0] irq_evt = {
      opt_primed && (opt_abs_q != !fiber_signal_detect_pin),
      shadow_take && partner_status_shadow != partner_status,
      rx_good && maint_rx_frame_count == '1,
      tx_frame_valid && maint_tx_frame_count == '1};
   wire [oamsc_pkg::IRQ_W-1:0] irq_w1c =
      (wr_en && hit_is && lane0) ? pwdata[oamsc_pkg::IRQ_W-1:0] : '0;

   always_comb begin
      status_now = '0;
      status_now.speed = link_speed;
      status_now.converter_side_flag = terminal_mode;
      status_now.loopback_flag = |loop_states;
      status_now.signal_loss_method = terminal_mode ? loss_method_pin : cpu_loss_method;
      status_now.diag_result_flag = terminal_mode ? diag_fail_pin : cpu_diag;
      status_now.copper_link_down_flag = terminal_mode ? copper_link_down : cpu_copper_down;
      status_now.optical_signal_absent = opt_abs_q;
      status_now.powerdown_flag = !powerdown_pin_n;
   end

   always_comb begin
      next_prdata = 32'h0;
      if (hit_ctrl) next_prdata[7:0] = ctrl_reg;
      if (hit_tx) next_prdata[7:0] = maint_tx_frame_count;
      if (hit_rx) next_prdata[7:0] = maint_rx_frame_count;
      if (hit_sh) next_prdata[7:0] = partner_status_shadow;
      if (hit_st) next_prdata[7:0] = status_now;
      if (hit_is) next_prdata[oamsc_pkg::IRQ_W-1:0] = irq_stat;
      if (hit_im) next_prdata[oamsc_pkg::IRQ_W-1:0] = irq_mask;
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   // A set mask bit silences that event
   assign irq = |(irq_stat & ~irq_mask);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         local_status <= '0;
         opt_abs_q <= 1'b1;
         opt_primed <= 1'b0;
      end else begin
         opt_primed <= 1'b1;
         if (rd_en) prdata <= next_prdata;
         local_status <= status_now;
         opt_abs_q <= !fiber_signal_detect_pin;
      end
   end

   // Counters: 8-bit wrap at 255, clear from control write wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         maint_tx_frame_count <= oamsc_pkg::CNT_RESET;
         maint_rx_frame_count <= oamsc_pkg::CNT_RESET;
         ctrl_reg <= oamsc_pkg::CTRL_RESET;
      end else begin
         if (wr_en && hit_ctrl && lane0) ctrl_reg <= pwdata[7:0];
         if (clr_cnt) maint_tx_frame_count <= oamsc_pkg::CNT_RESET;
         else if (tx_frame_valid) maint_tx_frame_count <= maint_tx_frame_count + 1'b1;
         if (clr_cnt) maint_rx_frame_count <= oamsc_pkg::CNT_RESET;
         else if (rx_good) maint_rx_frame_count <= maint_rx_frame_count + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_loss_method <= 1'b0;
         cpu_diag <= 1'b0;
         cpu_copper_down <= 1'b1;
      end else if (st_wr) begin
         cpu_loss_method <= pwdata[oamsc_pkg::BIT_LOSS];
         cpu_diag <= pwdata[oamsc_pkg::BIT_DIAG];
         cpu_copper_down <= pwdata[oamsc_pkg::BIT_CU_DOWN];
      end
   end

   // Shadow lives on power-on reset only, so warm reset cannot wipe it
   always_ff @(posedge pclk or negedge por_n) begin
      if (!por_n) begin
         partner_status_shadow <= oamsc_pkg::SHADOW_RST_CENTER;
         seen_por_release <= 1'b0;
      end else begin
         seen_por_release <= 1'b1;
         if (!seen_por_release) begin
            partner_status_shadow <= terminal_mode ?
               oamsc_pkg::SHADOW_RST_TERM : oamsc_pkg::SHADOW_RST_CENTER;
         end else if (shadow_take) begin
            partner_status_shadow <= partner_status;
         end
      end
   end

   // Sticky events: set beats a simultaneous write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
         irq_mask <= oamsc_pkg::IRQ_MASK_RESET;
      end else begin
         irq_stat <= (irq_stat & ~irq_w1c) | irq_evt;
         if (wr_en && hit_im && lane0) irq_mask <= pwdata[oamsc_pkg::IRQ_W-1:0];
      end
   end
endmodule // oamsc_regs

// *** rtl/oamsc_pkg.sv ***
// Package for the maintenance status and counter register bank.
// Assumes a 32-bit APB slave with one register per aligned word.
package oamsc_pkg;
   // Printed offsets are register indices; byte address is four times each
   localparam logic [7:0] IDX_CTRL = 8'h44;
   localparam logic [7:0] IDX_TX_CNT = 8'h4d;
   localparam logic [7:0] IDX_RX_CNT = 8'h4e;
   localparam logic [7:0] IDX_SHADOW = 8'h4f;
   localparam logic [7:0] IDX_STATUS = 8'h50;
   localparam logic [7:0] IDX_PARTNER = 8'h58;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h60;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
   localparam logic [7:0] CNT_RESET = 8'h00;
   localparam logic [7:0] CTRL_CLEAR_VAL = 8'h00;
   localparam logic [7:0] SHADOW_RST_TERM = 8'h07;
   localparam logic [7:0] SHADOW_RST_CENTER = 8'h47;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Status byte field positions
   localparam int BIT_SIDE = 6;
   localparam int BIT_LOOP = 5;
   localparam int BIT_LOSS = 4;
   localparam int BIT_DIAG = 3;
   localparam int BIT_CU_DOWN = 2;
   localparam int BIT_OPT_ABS = 1;
   localparam int BIT_PWR = 0;
   // Interrupt status bits
   localparam int IRQ_TX_WRAP = 0;
   localparam int IRQ_RX_WRAP = 1;
   localparam int IRQ_SHADOW_UPD = 2;
   localparam int IRQ_OPT_CHG = 3;
   localparam int IRQ_W = 4;
   localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

   typedef struct packed {
      logic speed;
      logic converter_side_flag;
      logic loopback_flag;
      logic signal_loss_method;
      logic diag_result_flag;
      logic copper_link_down_flag;
      logic optical_signal_absent;
      logic powerdown_flag;
   } oamsc_status_t;

   typedef struct packed {
      logic center_loop_state_a;
      logic center_loop_state_b;
      logic user_loop_state;
   } oamsc_loop_t;
endpackage

// *** tb/oamsc_regs_asserts.sv ***
// Checker for the maintenance status bank ports.
// Assumes local_status trails its sources by one pclk, and the optical absent bit by two.
`timescale 1ns/1ps
module oamsc_regs_asserts #(
   parameter int CNT_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pslverr,
   input wire logic terminal_mode,
   input wire oamsc_pkg::oamsc_loop_t loop_states,
   input wire logic loss_method_pin,
   input wire logic diag_fail_pin,
   input wire logic copper_link_down,
   input wire logic fiber_signal_detect_pin,
   input wire logic powerdown_pin_n,
   input wire oamsc_pkg::oamsc_status_t local_status
);
   oamsc_pkg::oamsc_status_t s;
   assign s = local_status;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Presetn gates the start so the reset edge itself is never judged
   sequence s_term;
      presetn && terminal_mode;
   endsequence
   a_side_flag: assert property (presetn |=>
      s.converter_side_flag == $past(terminal_mode)) else $error("side bit");
   a_loop_flag: assert property (presetn |=>
      s.loopback_flag == |$past(loop_states)) else $error("loop bit");
   a_opt_absent: assert property (presetn && $past(presetn) |=>
      s.optical_signal_absent != $past(fiber_signal_detect_pin, 2)) else $error("opt bit");
   a_pwr_flag: assert property (presetn |=>
      s.powerdown_flag != $past(powerdown_pin_n)) else $error("pwr bit");
   a_term_loss: assert property (s_term |=>
      s.signal_loss_method == $past(loss_method_pin)) else $error("loss bit");
   a_term_diag: assert property (s_term |=>
      s.diag_result_flag == $past(diag_fail_pin)) else $error("diag bit");
   a_term_copper: assert property (s_term |=>
      s.copper_link_down_flag == $past(copper_link_down)) else $error("copper bit");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
endmodule // oamsc_regs_asserts
bind oamsc_regs oamsc_regs_asserts #(.CNT_W(CNT_W)) asserts_u (.pclk, .presetn, .psel,
   .penable, .pslverr, .terminal_mode, .loop_states, .loss_method_pin, .diag_fail_pin,
   .copper_link_down, .fiber_signal_detect_pin, .powerdown_pin_n, .local_status);

// *** tb/oamsc_partner.sv ***
// Remote converter model on the optical side.
// Assumes the bench picks link state and the byte sent.
`timescale 1ns/1ps
module oamsc_partner (
   input wire logic pclk,
   input wire logic link_en,
   input wire logic [7:0] status_val,
   output logic opt_link_up,
   output logic [7:0] partner_status
);
   logic [7:0] last = 8'h00;
   initial begin
      opt_link_up = 1'b0;
      partner_status = 8'hff;
   end
   // Link down shows the inverse, never a stale copy
   always @(posedge pclk) begin
      opt_link_up <= link_en;
      partner_status <= link_en ? status_val : ~last;
      if (link_en) last <= status_val;
   end
endmodule // oamsc_partner

// *** tb/tb.sv ***
// Bench for the maintenance status bank over APB.
// Assumes the partner model drives the optical side.
`timescale 1ns/1ps
module tb;
   logic pclk = '0, presetn = '0, por_n = '0, psel = '0, penable = '0, pwrite = '0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, r;
   logic pready, pslverr, irq, e, opt_link_up, terminal_mode = '0, link_en = '0;
   logic tx_frame_valid = '0, rx_frame_done = '0, rx_crc_good = '0, rx_opcode_valid = '0;
   logic rx_dir_valid = '0, link_speed = '0, loss_method_pin = '0, diag_fail_pin = '0;
   logic copper_link_down = '0, fiber_signal_detect_pin = '1, powerdown_pin_n = '1;
   logic [7:0] pval = '0, partner_status;
   oamsc_pkg::oamsc_loop_t loop_states = '0;
   oamsc_pkg::oamsc_status_t local_status;
   int errors = 0, n_tests = 0, cyc = 0;
   always #10 pclk = ~pclk;
   oamsc_regs #(.CNT_W(8)) dut_u (.pclk, .presetn, .por_n, .paddr, .psel, .penable, .pwrite,
      .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .terminal_mode, .opt_link_up,
      .partner_status, .tx_frame_valid, .rx_frame_done, .rx_crc_good, .rx_opcode_valid,
      .rx_dir_valid, .loop_states, .link_speed, .loss_method_pin, .diag_fail_pin,
      .copper_link_down, .fiber_signal_detect_pin, .powerdown_pin_n, .local_status, .irq);
   oamsc_partner far_u (.pclk, .link_en, .status_val(pval), .opt_link_up, .partner_status);
   task automatic chk(input logic [31:0] g, x);
      n_tests++;
      if (g !== x) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic [31:0] a, input logic w, input logic [31:0] d);
      psel <= '1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk) penable <= '1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= '0;
      penable <= '0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [31:0] a, x);
      apb(a, '0, '0);
      chk(r, x);
   endtask
   task automatic fr(input logic t, input logic [2:0] v);
      tx_frame_valid <= t;
      rx_frame_done <= ~t;
      {rx_crc_good, rx_opcode_valid, rx_dir_valid} <= v;
      @(posedge pclk) tx_frame_valid <= '0;
      rx_frame_done <= '0;
      @(posedge pclk);
   endtask
   task test_done;
      if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         $display("[ERR] %0t timeout", $time);
         test_done();
      end
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= '1;
      por_n <= '1;
      @(posedge pclk);
      rd(32'h134, 32'h0);
      rd(32'h13c, 32'h47);
      rd(32'h140, 32'h04);
      for (int i = 0; i < 8; i++) fr('0, i[2:0]);
      repeat (3) fr('1, '0);
      rd(32'h134, 32'h3);
      rd(32'h138, 32'h1);
      apb(32'h110, '1, 32'h0);
      rd(32'h134, 32'h0);
      rd(32'h138, 32'h0);
      apb(32'h180, '1, 32'hf);
      repeat (256) fr('1, '0);
      rd(32'h134, 32'h0);
      rd(32'h180, 32'h1);
      chk(irq, 32'h1);
      apb(32'h184, '1, 32'h1);
      rd(32'h184, 32'h1);
      chk(irq, 32'h0);
      apb(32'h180, '1, 32'h1);
      rd(32'h180, 32'h0);
      apb(32'h140, '1, 32'h18);
      rd(32'h140, 32'h18);
      terminal_mode <= '1;
      {link_speed, loss_method_pin, diag_fail_pin, copper_link_down} <= 4'hf;
      {fiber_signal_detect_pin, powerdown_pin_n} <= 2'b00;
      loop_states <= 3'b100;
      apb(32'h140, '1, 32'h0);
      rd(32'h140, 32'hff);
      chk(local_status, 32'hff);
      {link_speed, loss_method_pin, diag_fail_pin, copper_link_down} <= 4'h0;
      {fiber_signal_detect_pin, powerdown_pin_n, loop_states} <= 5'b11001;
      apb(32'h200, '0, '0);
      chk(e, 32'h1);
      chk(r, 32'h0);
      rd(32'h140, 32'h60);
      terminal_mode <= '0;
      pval <= 8'h5a;
      link_en <= '1;
      repeat (4) @(posedge pclk);
      rd(32'h13c, 32'h5a);
      link_en <= '0;
      presetn <= '0;
      @(posedge pclk) presetn <= '1;
      @(posedge pclk);
      rd(32'h13c, 32'h5a);
      pval <= 8'h33;
      link_en <= '1;
      repeat (4) @(posedge pclk);
      rd(32'h13c, 32'h33);
      powerdown_pin_n <= '0;
      pval <= 8'h99;
      repeat (4) @(posedge pclk);
      rd(32'h13c, 32'h33);
      powerdown_pin_n <= '1;
      terminal_mode <= '1;
      pval <= 8'h66;
      repeat (4) @(posedge pclk);
      rd(32'h13c, 32'h66);
      test_done();
   end
endmodule // tb
